/* File: include/iglf_pkg.sv */
// ****************************************************************
// input line glitch filter shared constants
// ****************************************************************
package iglf_pkg;

    // core clock period
    localparam int unsigned CLK_NS         = 8;

    // register port widths
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;

    // passed pulse widths of the four fixed settings, in ns
    localparam int unsigned PASS_5US_NS    = 5000;
    localparam int unsigned PASS_1US_NS    = 1000;
    localparam int unsigned PASS_500NS_NS  = 500;
    localparam int unsigned PASS_100NS_NS  = 100;

    // filter clock period is half the passed width, rounded down to cycles
    localparam int unsigned TB_5US_CYC     = PASS_5US_NS / 2 / CLK_NS;
    localparam int unsigned TB_1US_CYC     = PASS_1US_NS / 2 / CLK_NS;
    localparam int unsigned TB_500NS_CYC   = PASS_500NS_NS / 2 / CLK_NS;
    localparam int unsigned TB_100NS_CYC   = PASS_100NS_NS / 2 / CLK_NS;
    localparam int unsigned TB_CNT_W       = 10;

    // timebase selection held in each line's filter word
    typedef enum logic [2:0] {
        IGLF_TB_5US,
        IGLF_TB_1US,
        IGLF_TB_500NS,
        IGLF_TB_100NS,
        IGLF_TB_EXT
    } iglf_tb_sel_t;

    // filter word layout
    localparam int unsigned FILT_EN_BIT    = 0;
    localparam int unsigned FILT_SEL_LSB   = 1;
    localparam int unsigned FILT_SEL_W     = 3;
    localparam int unsigned FILT_SRC_LSB   = 4;
    localparam int unsigned FILT_SRC_W     = 6;
    localparam int unsigned FILT_W         = 10;

    // reset values
    localparam logic [9:0]  FILT_RST       = 10'h003;  // enabled, 1 us setting
    localparam logic [31:0] ZERO_RST       = 32'h0000_0000;

    // register offsets
    localparam logic [7:0]  ADR_FILT_BASE  = 8'h00;
    localparam logic [7:0]  ADR_IN_POL     = 8'h20;
    localparam logic [7:0]  ADR_IN_LEVEL   = 8'h21;
    localparam logic [7:0]  ADR_IN_RAW     = 8'h22;
    localparam logic [7:0]  ADR_OUT_EN     = 8'h25;
    localparam logic [7:0]  ADR_OUT_IDLE   = 8'h26;
    localparam logic [7:0]  ADR_OUT_POL    = 8'h27;
    localparam logic [7:0]  ADR_TRIG_OE    = 8'h28;
    localparam logic [7:0]  ADR_TRIG_OUT   = 8'h29;
    localparam logic [7:0]  ADR_TRIG_IN    = 8'h2A;

endpackage : iglf_pkg

/* File: rtl/iglf_sync.sv */
// ****************************************************************
// two flop level synchroniser
// ****************************************************************
module iglf_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

    chk_sync_two_stage: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $past(nrst, 2) |-> dout == $past(din, 2))
        else $error("synchroniser output is not the input two cycles back");

endmodule : iglf_sync

/* File: rtl/iglf_line.sv */
// ****************************************************************
// one line debounce filter
// ****************************************************************
module iglf_line (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // control
    input  wire logic en,    // filter enabled
    input  wire logic tick,  // one cycle per filter clock rising edge
    // level
    input  wire logic din,   // synchronised raw level
    output logic      dout_q
);

    logic pend_q;
    logic cnt_q;

    // pending level and filter edge count; any disagreeing sample aborts
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pend_q <= 1'b0;
            cnt_q  <= 1'b0;
        end else if (!en) begin
            pend_q <= din;
            cnt_q  <= 1'b0;
        end else if (din == dout_q || din != pend_q) begin
            pend_q <= din;
            cnt_q  <= 1'b0;
        end else if (tick) begin
            cnt_q  <= ~cnt_q;
        end
    end

    // output takes the pending level on the second filter edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dout_q <= 1'b0;
        end else if (!en) begin
            dout_q <= din;
        end else if (din == pend_q && din != dout_q && tick && cnt_q) begin
            dout_q <= pend_q;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_change_on_tick: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $changed(dout_q) && $past(en) |-> $past(tick) && $past(cnt_q))
        else $error("filtered level changed off a second filter edge");

    chk_glitch_aborts: assert property (
        @(posedge core_clk) disable iff (!nrst)
        en && din == dout_q |=> cnt_q == 1'b0 && pend_q == $past(din))
        else $error("disagreeing sample did not abort qualification");

    chk_sample_each_edge: assert property (
        @(posedge core_clk) disable iff (!nrst)
        en && din != pend_q |=> pend_q == $past(din) && !cnt_q)
        else $error("new level not captured on the sampling edge");

    chk_second_edge_pass: assert property (
        @(posedge core_clk) disable iff (!nrst)
        en && cnt_q && tick && din == pend_q && din != dout_q |=> dout_q == $past(din))
        else $error("held level not passed on the second filter edge");

    chk_bypass_follow: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !en |=> dout_q == $past(din))
        else $error("disabled filter does not follow its input");

    cov_level_passed: cover property (
        @(posedge core_clk) disable iff (!nrst)
        en && $changed(dout_q));

    cov_glitch_aborted: cover property (
        @(posedge core_clk) disable iff (!nrst)
        en && cnt_q && din == dout_q);

    cov_bypass_used: cover property (
        @(posedge core_clk) disable iff (!nrst)
        !en && $changed(dout_q));

endmodule : iglf_line

/* File: rtl/iglf_top.sv */
module iglf_top #(
    parameter int unsigned N_IN   = 26,
    parameter int unsigned N_OUT  = 8,
    parameter int unsigned N_TRIG = 8,
    parameter int unsigned N_INT  = 4
) (
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           nrst,
    // register port
    input  wire logic [iglf_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [iglf_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [iglf_pkg::DATA_W-1:0]    reg_rdata,
    // function input lines
    input  wire logic [N_IN-1:0]                func_in,
    output logic      [N_IN-1:0]                func_level,
    // function output lines
    input  wire logic [N_OUT-1:0]               out_func,
    output logic      [N_OUT-1:0]               out_switch_on,
    // inter-board trigger lines
    input  wire logic [N_TRIG-1:0]              trig_in,
    output logic      [N_TRIG-1:0]              trig_out,
    output logic      [N_TRIG-1:0]              trig_oe,
    // internal timebase candidates
    input  wire logic [N_INT-1:0]               int_sig
);

    localparam int unsigned NSRC = N_IN + N_OUT + N_TRIG + N_INT;

    // elaboration checks
    if (N_IN > iglf_pkg::DATA_W || N_OUT > iglf_pkg::DATA_W || N_TRIG > iglf_pkg::DATA_W) begin
        $error("line counts must fit one register word");
    end
    if (NSRC > (1 << iglf_pkg::FILT_SRC_W)) begin
        $error("too many filter clock sources for the source field");
    end
    if (N_IN + N_OUT != 34) begin
        $error("the device has 34 function lines");
    end
    if (iglf_pkg::TB_5US_CYC > (1 << iglf_pkg::TB_CNT_W) || iglf_pkg::TB_100NS_CYC < 2) begin
        $error("fixed timebase does not fit the divider");
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [iglf_pkg::FILT_W-1:0] filt_q [N_IN];
    logic [N_IN-1:0]             in_pol_q;
    logic [N_OUT-1:0]            out_en_q;
    logic [N_OUT-1:0]            out_idle_q;
    logic [N_OUT-1:0]            out_pol_q;
    logic [N_OUT-1:0]            out_used_q;
    logic [N_TRIG-1:0]           trig_oe_q;
    logic [N_TRIG-1:0]           trig_out_q;
    logic [iglf_pkg::DATA_W-1:0] rdata_d;
    logic [iglf_pkg::DATA_W-1:0] rdata_q;

    // internal state
    logic [N_IN-1:0]   in_sync;
    logic [N_TRIG-1:0] trig_sync;
    logic [N_IN-1:0]   filt_out;
    logic [N_OUT-1:0]  out_level;
    logic [N_OUT-1:0]  out_sw_d;
    logic [N_OUT-1:0]  out_sw_q;
    logic [NSRC-1:0]   src_vec;
    logic [NSRC-1:0]   src_prev_q;
    logic [NSRC-1:0]   src_rise;
    logic [3:0]        fix_tick;
    logic [N_IN-1:0]   line_tick;

    // per line filter words, one register each
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < N_IN; i++) begin
                filt_q[i] <= iglf_pkg::FILT_RST;
            end
        end else if (reg_wr) begin
            for (int i = 0; i < N_IN; i++) begin
                if (reg_addr == iglf_pkg::ADR_FILT_BASE + iglf_pkg::ADDR_W'(i)) begin
                    filt_q[i] <= reg_wdata[iglf_pkg::FILT_W-1:0];
                end
            end
        end
    end

    // input polarity, reset active high
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            in_pol_q <= iglf_pkg::ZERO_RST[N_IN-1:0];
        end else if (reg_wr && reg_addr == iglf_pkg::ADR_IN_POL) begin
            in_pol_q <= reg_wdata[N_IN-1:0];
        end
    end

    // output line control
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_en_q   <= iglf_pkg::ZERO_RST[N_OUT-1:0];
            out_idle_q <= iglf_pkg::ZERO_RST[N_OUT-1:0];
            out_pol_q  <= iglf_pkg::ZERO_RST[N_OUT-1:0];
        end else if (reg_wr) begin
            if (reg_addr == iglf_pkg::ADR_OUT_EN) begin
                out_en_q <= reg_wdata[N_OUT-1:0];
            end
            if (reg_addr == iglf_pkg::ADR_OUT_IDLE) begin
                out_idle_q <= reg_wdata[N_OUT-1:0];
            end
            if (reg_addr == iglf_pkg::ADR_OUT_POL) begin
                out_pol_q <= reg_wdata[N_OUT-1:0];
            end
        end
    end

    // an output counts as used once it has been enabled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_used_q <= iglf_pkg::ZERO_RST[N_OUT-1:0];
        end else begin
            out_used_q <= out_used_q | out_en_q;
        end
    end

    // trigger line drive, undriven after reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trig_oe_q  <= iglf_pkg::ZERO_RST[N_TRIG-1:0];
            trig_out_q <= iglf_pkg::ZERO_RST[N_TRIG-1:0];
        end else if (reg_wr) begin
            if (reg_addr == iglf_pkg::ADR_TRIG_OE) begin
                trig_oe_q <= reg_wdata[N_TRIG-1:0];
            end
            if (reg_addr == iglf_pkg::ADR_TRIG_OUT) begin
                trig_out_q <= reg_wdata[N_TRIG-1:0];
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        for (int i = 0; i < N_IN; i++) begin
            if (reg_addr == iglf_pkg::ADR_FILT_BASE + iglf_pkg::ADDR_W'(i)) begin
                rdata_d[iglf_pkg::FILT_W-1:0] = filt_q[i];
            end
        end
        unique case (reg_addr)
            iglf_pkg::ADR_IN_POL:   rdata_d[N_IN-1:0]   = in_pol_q;
            iglf_pkg::ADR_IN_LEVEL: rdata_d[N_IN-1:0]   = func_level;
            iglf_pkg::ADR_IN_RAW:   rdata_d[N_IN-1:0]   = in_sync;
            iglf_pkg::ADR_OUT_EN:   rdata_d[N_OUT-1:0]  = out_en_q;
            iglf_pkg::ADR_OUT_IDLE: rdata_d[N_OUT-1:0]  = out_idle_q;
            iglf_pkg::ADR_OUT_POL:  rdata_d[N_OUT-1:0]  = out_pol_q;
            iglf_pkg::ADR_TRIG_OE:  rdata_d[N_TRIG-1:0] = trig_oe_q;
            iglf_pkg::ADR_TRIG_OUT: rdata_d[N_TRIG-1:0] = trig_out_q;
            iglf_pkg::ADR_TRIG_IN:  rdata_d[N_TRIG-1:0] = trig_sync;
            default: ;
        endcase
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= iglf_pkg::ZERO_RST;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= iglf_pkg::ZERO_RST;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************************************
    // synchronisers and filter clock sources
    // ****************************************************************
    iglf_sync #(.WIDTH(N_IN)) u_in_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      (func_in),
        .dout     (in_sync)
    );

    iglf_sync #(.WIDTH(N_TRIG)) u_trig_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      (trig_in),
        .dout     (trig_sync)
    );

    // every line, trigger and internal signal may clock a filter
    assign src_vec = {int_sig, trig_sync, out_level, in_sync};

    // rising edges of the candidate sources
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            src_prev_q <= '0;
        end else begin
            src_prev_q <= src_vec;
        end
    end

    assign src_rise = src_vec & ~src_prev_q;

    // fixed timebases as one cycle pulses every half passed width
    localparam int unsigned TB_CYC [4] = '{iglf_pkg::TB_5US_CYC, iglf_pkg::TB_1US_CYC,
                                          iglf_pkg::TB_500NS_CYC, iglf_pkg::TB_100NS_CYC};

    for (genvar k = 0; k < 4; k++) begin : g_tb
        logic [iglf_pkg::TB_CNT_W-1:0] cnt_q;
        // wrapping divider per setting
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                cnt_q <= '0;
            end else if (cnt_q == iglf_pkg::TB_CNT_W'(TB_CYC[k] - 1)) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
        assign fix_tick[k] = (cnt_q == iglf_pkg::TB_CNT_W'(TB_CYC[k] - 1));
    end

    // ****************************************************************
    // per line filters
    // ****************************************************************
    for (genvar i = 0; i < N_IN; i++) begin : g_line
        iglf_pkg::iglf_tb_sel_t         sel;
        logic [iglf_pkg::FILT_SRC_W-1:0] src_idx;

        assign sel     = iglf_pkg::iglf_tb_sel_t'(
                         filt_q[i][iglf_pkg::FILT_SEL_LSB +: iglf_pkg::FILT_SEL_W]);
        assign src_idx = filt_q[i][iglf_pkg::FILT_SRC_LSB +: iglf_pkg::FILT_SRC_W];

        // timebase pick; undefined codes fall back to the 1 us setting
        always_comb begin
            unique case (sel)
                iglf_pkg::IGLF_TB_5US:   line_tick[i] = fix_tick[0];
                iglf_pkg::IGLF_TB_1US:   line_tick[i] = fix_tick[1];
                iglf_pkg::IGLF_TB_500NS: line_tick[i] = fix_tick[2];
                iglf_pkg::IGLF_TB_100NS: line_tick[i] = fix_tick[3];
                iglf_pkg::IGLF_TB_EXT: begin
                    line_tick[i] = (32'(src_idx) < NSRC) ? src_rise[src_idx] : 1'b0;
                end
                default:                 line_tick[i] = fix_tick[1];
            endcase
        end

        iglf_line u_line (
            .core_clk (core_clk),
            .nrst     (nrst),
            .en       (filt_q[i][iglf_pkg::FILT_EN_BIT]),
            .tick     (line_tick[i]),
            .din      (in_sync[i]),
            .dout_q   (filt_out[i])
        );
    end

    // filtered level to counters, low after reset
    assign func_level = filt_out ^ in_pol_q;

    // ****************************************************************
    // output lines and trigger drive
    // ****************************************************************
    // output level: routed function, or idle default when disabled
    always_comb begin
        for (int j = 0; j < N_OUT; j++) begin
            out_level[j] = out_en_q[j] ? (out_func[j] ^ out_pol_q[j]) : out_idle_q[j];
            out_sw_d[j]  = (out_en_q[j] || out_used_q[j]) ? ~out_level[j] : 1'b0;
        end
    end

    // switch conducts for a low level; off until first use
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_sw_q <= '0;
        end else begin
            out_sw_q <= out_sw_d;
        end
    end

    assign out_switch_on = out_sw_q;
    assign trig_out      = trig_out_q;
    assign trig_oe       = trig_oe_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_tick_100ns_period: assert property (
        @(posedge core_clk) disable iff (!nrst)
        fix_tick[3] |=> !fix_tick[3] [*5] ##1 fix_tick[3])
        else $error("100 ns timebase period is not six cycles");

    chk_unused_out_off: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !out_used_q[0] && !out_en_q[0] |=> !out_switch_on[0])
        else $error("unused output switch is conducting");

    chk_idle_low_default: assert property (
        @(posedge core_clk) disable iff (!nrst)
        out_used_q[0] && !out_en_q[0] && !out_idle_q[0] |=> out_switch_on[0])
        else $error("used output did not idle low");

    chk_trig_hiz_reset: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(trig_oe[0]) |-> $past(reg_wr) && $past(reg_addr) == iglf_pkg::ADR_TRIG_OE)
        else $error("trigger line driven without a software write");

    chk_rdata_idle_zero: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data present without a read strobe");

    chk_filt_word_write: assert property (
        @(posedge core_clk) disable iff (!nrst)
        reg_wr && reg_addr == iglf_pkg::ADR_FILT_BASE
        |=> filt_q[0] == $past(reg_wdata[iglf_pkg::FILT_W-1:0]))
        else $error("filter word write did not land");

    cov_ext_timebase: cover property (
        @(posedge core_clk) disable iff (!nrst)
        g_line[0].sel == iglf_pkg::IGLF_TB_EXT && line_tick[0]);

    cov_out_used_idle: cover property (
        @(posedge core_clk) disable iff (!nrst)
        $fell(out_en_q[0]));

endmodule : iglf_top

/* File: dv/iglf_field.sv */
// ****************************************************************
// field side: raw input lines and pulled-up trigger wires
// ****************************************************************
module iglf_field (
    // clock
    input  wire logic        core_clk,
    // trigger drive from the block
    input  wire logic [7:0]  trig_out,
    input  wire logic [7:0]  trig_oe,
    // wire levels
    output logic      [25:0] func_in,
    output logic      [7:0]  trig_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // undriven inputs rest at the pull-down level
    initial func_in = '0;

    // a released trigger wire floats to the pull-up level
    assign trig_in = (trig_oe & trig_out) | ~trig_oe;

    // one high pulse of w cycles on line i, changed just after an edge
    task automatic pulse(input int i, input int w);
        @(posedge core_clk);
        func_in[i] <= 1'b1;
        repeat (w) @(posedge core_clk);
        func_in[i] <= 1'b0;
    endtask : pulse
endmodule : iglf_field

/* File: dv/test_iglf_top.sv */
// ****************************************************************
// bench for the input line glitch filter
// ****************************************************************
module test_iglf_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int EXT_T = 8;  // period of the internal timebase
    logic        core_clk, nrst, reg_wr, reg_rd, rd_seen;
    logic [7:0]  reg_addr, out_func, out_switch_on, trig_in, trig_out, trig_oe;
    logic [31:0] reg_wdata, reg_rdata, rng, exp_q[$];
    logic [25:0] func_in, func_level, seen;
    logic [3:0]  int_sig;
    int          fail_count, n_tests, i, n;
    logic [31:0] w_c[5] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0005,
                            32'h0000_0007, 32'h0000_02A9};
    int          t_c[5] = '{iglf_pkg::TB_5US_CYC, iglf_pkg::TB_1US_CYC,
                            iglf_pkg::TB_500NS_CYC, iglf_pkg::TB_100NS_CYC, EXT_T};

    iglf_top DUT (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
                  .reg_rdata, .func_in, .func_level, .out_func, .out_switch_on,
                  .trig_in, .trig_out, .trig_oe, .int_sig);
    iglf_field field (.core_clk, .trig_out, .trig_oe, .func_in, .trig_in);

    // free running core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // internal timebase with even duty cycle
    always begin
        repeat (EXT_T / 2) @(posedge core_clk);
        int_sig <= int_sig ^ 4'h1;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk) rd_seen <= reg_rd;
    always @(negedge core_clk) begin
        seen = seen | func_level;
        if (rd_seen && exp_q.size() > 0)
            chk(reg_rdata, exp_q.pop_front());
        else
            chk(reg_rdata, 32'h0000_0000);
    end

    // watchdog
    initial begin
        repeat (30000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, out_func, int_sig} = '0;
        {rd_seen, seen, fail_count, n_tests} = '0;
        rng = 32'h1736;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        chk({6'h0, func_level}, 32'h0000_0000);
        chk({8'h0, out_switch_on, trig_oe, trig_out}, 32'h0000_0000);
        chk({24'h0, trig_in}, 32'h0000_00FF);
        rd(8'h00, 32'h0000_0003);
        rd(8'h19, 32'h0000_0003);
        rd(8'h20, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        // every timebase: blocked widths, then one passed pulse
        for (i = 0; i < 5; i++) begin
            wr(8'h00, w_c[i]);
            seen = '0;
            field.pulse(0, t_c[i]);
            field.pulse(0, t_c[i] - 1);
            field.pulse(0, t_c[i] - 1);
            repeat (2 * t_c[i] + 6) @(negedge core_clk);
            chk(32'(seen[0]), 32'h0000_0000);
            fork
                field.pulse(0, 2 * t_c[i] + 2);
            join_none
            for (n = 0; n < 3 * t_c[i] && func_level[0] !== 1'b1; n++)
                @(negedge core_clk);
            chk(32'(n >= t_c[i] + 5 && n <= 2 * t_c[i] + 4), 32'h1);
            rd(8'h21, 32'h0000_0001);
            repeat (3 * t_c[i] + 8) @(negedge core_clk);
            chk(32'(func_level[0]), 32'h0000_0000);
        end
        // line 1 unfiltered passes a short pulse, line 0 keeps its own word
        wr(8'h01, 32'h0000_0000);
        fork
            field.pulse(1, 2);
        join_none
        repeat (5) @(negedge core_clk);
        chk(32'(func_level[1]), 32'h1);
        rd(8'h00, 32'h0000_02A9);
        wr(8'h20, 32'h0000_0004);
        rd(8'h21, 32'h0000_0004);
        // output lines with random levels and polarity
        rng = xs(rng);
        out_func <= rng[7:0];
        wr(8'h25, 32'h0000_00FF);
        repeat (2) @(negedge core_clk);
        chk({24'h0, out_switch_on}, {24'h0, ~out_func});
        wr(8'h27, {24'h0, rng[15:8]});
        repeat (2) @(negedge core_clk);
        chk({24'h0, out_switch_on}, {24'h0, ~(out_func ^ rng[15:8])});
        wr(8'h25, 32'h0000_0000);
        repeat (2) @(negedge core_clk);
        chk({24'h0, out_switch_on}, 32'h0000_00FF);
        wr(8'h26, 32'h0000_00FF);
        repeat (2) @(negedge core_clk);
        chk({24'h0, out_switch_on}, 32'h0000_0000);
        rd(8'h25, 32'h0000_0000);
        rd(8'h26, 32'h0000_00FF);
        rd(8'h27, {24'h0, rng[15:8]});
        // synchronised raw level of a line held high
        fork
            field.pulse(3, 40);
        join_none
        repeat (4) @(posedge core_clk);
        rd(8'h22, 32'h0000_0008);
        // driven and released trigger wires
        wr(8'h28, 32'h0000_000F);
        wr(8'h29, 32'h0000_0005);
        repeat (3) @(posedge core_clk);
        rd(8'h2A, 32'h0000_00F5);
        rd(8'h28, 32'h0000_000F);
        rd(8'h29, 32'h0000_0005);
        repeat (3) @(negedge core_clk);
        chk({16'h0, trig_oe, trig_out}, 32'h0000_0F05);
        end_of_test();
    end
endmodule : test_iglf_top
